// file: src/ccs_clock_control.sv
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module ccs_clock_control (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// Fuses, as stored
	input  wire logic [1:0]  clock_source_select_in,
	input  wire logic [1:0]  startup_time_select_in,
	input  wire logic        divide_by_eight_fuse_in,
	input  wire logic [6:0]  cal_byte_fast_in,
	input  wire logic [6:0]  cal_byte_slow_in,
	// Clock sources, sampled in the system clock domain
	input  wire logic        external_clock_input_in,
	input  wire logic        rc_osc_tick_in,
	input  wire logic        lf_osc_tick_in,
	input  wire logic        wdt_osc_tick_in,
	// Sleep control
	input  wire logic        power_down_in,
	input  wire logic        wake_in,
	input  wire logic        ext_irq_async_in,
	input  wire logic        core_halt_in,
	input  wire logic        io_halt_in,
	input  wire logic        adc_halt_in,
	// Clock domain enables and status
	output logic             core_clk_en_out,
	output logic             io_clk_en_out,
	output logic             flash_clk_en_out,
	output logic             adc_clk_en_out,
	output logic             cpu_run_out,
	output logic             rc_osc_en_out,
	output logic             lf_osc_en_out,
	output logic             wdt_osc_en_out,
	output logic [6:0]       oscillator_trim_register_out,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in
);

	typedef struct packed {
		ccs_pkg::ccs_state_type state;
		logic [1:0]  src_sel;
		logic [1:0]  startup_time_select;
		logic        div8;
		logic [6:0]  trim;
		logic [2:0]  pre_cnt;
		logic        rc_half;
		logic        ext_prev;
		logic        core_en;
		logic        io_en;
		logic        flash_en;
		logic        adc_en;
		logic        run;
		logic        rc_osc_en;
		logic        lf_osc_en;
		logic        wdt_osc_en;
		logic        awready;
		logic        wready;
		logic        aw_hold;
		logic [7:0]  awaddr;
		logic        w_hold;
		logic [6:0]  wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ccs_main_type;

	ccs_main_type s_r;
	ccs_main_type s_nxt;

	logic                          src_tick;
	logic                          sys_tick;
	logic                          running;
	logic                          ctr_load;
	logic [ccs_pkg::CCS_CNT_W-1:0] ctr_val;
	logic                          ctr_tick;
	logic                          ctr_done;
	logic [31:0]                   status_word;

	function automatic logic [1:0] ccs_decode(input logic [7:0] addr);
		if (addr[7:2] == ccs_pkg::CCS_TRIM_OFS[7:2]) begin
			return ccs_pkg::CCS_DEC_TRIM;
		end else if (addr[7:2] == ccs_pkg::CCS_STATUS_OFS[7:2]) begin
			return ccs_pkg::CCS_DEC_STATUS;
		end
		return ccs_pkg::CCS_DEC_NONE;
	endfunction

	ccs_tick_counter u_startup_counter (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.load_in    (ctr_load),
		.count_in   (ctr_val),
		.tick_in    (ctr_tick),
		.busy_out   (),
		.done_out   (ctr_done)
	);

	always_comb begin
		status_word = '0;
		status_word[ccs_pkg::CCS_ST_STATE_LSB +: 6] = s_r.state;
		status_word[ccs_pkg::CCS_ST_SRC_LSB +: 2] = s_r.src_sel;
		status_word[ccs_pkg::CCS_ST_SUT_LSB +: 2] = s_r.startup_time_select;
		status_word[ccs_pkg::CCS_ST_DIV8_BIT] = s_r.div8;
		status_word[ccs_pkg::CCS_ST_RUN_BIT] = s_r.run;
	end

	////////////////////////////////////////////////////////////////////////
	// Source selection and start-up prescaler
	always_comb begin
		s_nxt = s_r;
		ctr_load = 1'b0;
		ctr_val = '0;
		ctr_tick = 1'b0;

		// External pin is a level; one tick per rising edge
		case (s_r.src_sel)
			ccs_pkg::CCS_SRC_EXT: begin
				src_tick = external_clock_input_in & ~s_r.ext_prev;
			end
			ccs_pkg::CCS_SRC_RC48: begin
				src_tick = rc_osc_tick_in & s_r.rc_half;
			end
			ccs_pkg::CCS_SRC_RC96: begin
				src_tick = rc_osc_tick_in;
			end
			default: begin
				src_tick = lf_osc_tick_in;
			end
		endcase
		s_nxt.ext_prev = external_clock_input_in;
		s_nxt.rc_half = s_r.rc_half ^ rc_osc_tick_in;

		// Fixed divide by 8; run-time prescaling lives elsewhere
		s_nxt.pre_cnt = s_r.pre_cnt + {2'h0, src_tick};
		sys_tick = src_tick &
			(~s_r.div8 | (s_r.pre_cnt == ccs_pkg::CCS_DIV8_LAST));

		////////////////////////////////////////////////////////////////////
		// Start-up and sleep sequencing
		case (s_r.state)
			ccs_pkg::CCS_ST_RESET: begin
				ctr_load = 1'b1;
				case (s_r.startup_time_select)
					ccs_pkg::CCS_SUT_SHORT: begin
						ctr_val = ccs_pkg::CCS_RST_CK;
						s_nxt.state = ccs_pkg::CCS_ST_RST_CK;
					end
					ccs_pkg::CCS_SUT_MID: begin
						ctr_val = ccs_pkg::CCS_WDT_4MS;
						s_nxt.state = ccs_pkg::CCS_ST_RST_WDT;
					end
					default: begin
						// Reserved code takes the longest delay
						ctr_val = ccs_pkg::CCS_WDT_64MS;
						s_nxt.state = ccs_pkg::CCS_ST_RST_WDT;
					end
				endcase
			end
			ccs_pkg::CCS_ST_RST_WDT: begin
				ctr_tick = wdt_osc_tick_in;
				if (ctr_done) begin
					ctr_load = 1'b1;
					ctr_val = ccs_pkg::CCS_RST_CK;
					s_nxt.state = ccs_pkg::CCS_ST_RST_CK;
				end
			end
			ccs_pkg::CCS_ST_RST_CK, ccs_pkg::CCS_ST_WAKE: begin
				ctr_tick = src_tick;
				if (ctr_done) begin
					s_nxt.state = ccs_pkg::CCS_ST_RUN;
				end
			end
			ccs_pkg::CCS_ST_RUN: begin
				if (power_down_in) begin
					s_nxt.state = ccs_pkg::CCS_ST_SLEEP;
				end
			end
			ccs_pkg::CCS_ST_SLEEP: begin
				// Async interrupt wakes without any peripheral clock
				if (wake_in || ext_irq_async_in) begin
					ctr_load = 1'b1;
					ctr_val = ccs_pkg::CCS_WAKE_CK;
					s_nxt.state = ccs_pkg::CCS_ST_WAKE;
				end
			end
			default: begin
				s_nxt.state = ccs_pkg::CCS_ST_RESET;
			end
		endcase

		////////////////////////////////////////////////////////////////////
		// Clock domain enables
		running = (s_r.state == ccs_pkg::CCS_ST_RUN);
		s_nxt.core_en = running & sys_tick & ~core_halt_in;
		s_nxt.flash_en = running & sys_tick & ~core_halt_in;
		s_nxt.io_en = running & sys_tick & ~io_halt_in;
		s_nxt.adc_en = running & sys_tick & ~adc_halt_in;
		s_nxt.run = (s_nxt.state == ccs_pkg::CCS_ST_RUN);
		s_nxt.rc_osc_en = ((s_r.src_sel == ccs_pkg::CCS_SRC_RC48) ||
			(s_r.src_sel == ccs_pkg::CCS_SRC_RC96)) &&
			(s_nxt.state != ccs_pkg::CCS_ST_SLEEP);
		s_nxt.lf_osc_en = (s_r.src_sel == ccs_pkg::CCS_SRC_LF) &&
			(s_nxt.state != ccs_pkg::CCS_ST_SLEEP);
		s_nxt.wdt_osc_en = ccs_pkg::CCS_WDT_EN_RST;

		////////////////////////////////////////////////////////////////////
		// AXI4-Lite write: address and data in either order
		if (s_axi_awvalid_in && s_r.awready) begin
			s_nxt.aw_hold = 1'b1;
			s_nxt.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_r.wready) begin
			s_nxt.w_hold = 1'b1;
			s_nxt.wdata = s_axi_wdata_in[6:0];
			s_nxt.wstrb0 = s_axi_wstrb_in[0];
		end
		s_nxt.bvalid = s_r.bvalid & ~s_axi_bready_in;
		if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
			s_nxt.aw_hold = 1'b0;
			s_nxt.w_hold = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = ccs_pkg::CCS_RESP_OKAY;
			// Status is read-only: a write there is accepted and dropped
			if (ccs_decode(s_r.awaddr) == ccs_pkg::CCS_DEC_NONE) begin
				s_nxt.bresp = ccs_pkg::CCS_RESP_SLVERR;
			end
			if ((ccs_decode(s_r.awaddr) == ccs_pkg::CCS_DEC_TRIM) &&
				s_r.wstrb0) begin
				s_nxt.trim = s_r.wdata;
			end
		end
		s_nxt.awready = ~s_nxt.aw_hold & ~s_nxt.bvalid;
		s_nxt.wready = ~s_nxt.w_hold & ~s_nxt.bvalid;

		// AXI4-Lite read
		s_nxt.rvalid = s_r.rvalid & ~s_axi_rready_in;
		if (s_axi_arvalid_in && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = ccs_pkg::CCS_RESP_OKAY;
			case (ccs_decode(s_axi_araddr_in))
				ccs_pkg::CCS_DEC_TRIM: begin
					s_nxt.rdata = {25'h0000000, s_r.trim};
				end
				ccs_pkg::CCS_DEC_STATUS: begin
					s_nxt.rdata = status_word;
				end
				default: begin
					s_nxt.rdata = '0;
					s_nxt.rresp = ccs_pkg::CCS_RESP_SLVERR;
				end
			endcase
		end
		s_nxt.arready = ~s_nxt.rvalid;

		////////////////////////////////////////////////////////////////////
		// Reset: fuses caught here and, except trim (written over AXI4-Lite), never touched again
		if (!rst_n_in) begin
			s_nxt = '0;
			s_nxt.state = ccs_pkg::CCS_ST_RESET;
			s_nxt.src_sel = clock_source_select_in;
			s_nxt.startup_time_select = startup_time_select_in;
			s_nxt.div8 = ~divide_by_eight_fuse_in;
			// Only the fast byte: 4.8 MHz is the same oscillator halved
			s_nxt.trim = cal_byte_fast_in;
			s_nxt.wdt_osc_en = ccs_pkg::CCS_WDT_EN_RST;
			s_nxt.awready = ccs_pkg::CCS_READY_RST;
			s_nxt.wready = ccs_pkg::CCS_READY_RST;
			s_nxt.arready = ccs_pkg::CCS_READY_RST;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign core_clk_en_out = s_r.core_en;
	assign io_clk_en_out = s_r.io_en;
	assign flash_clk_en_out = s_r.flash_en;
	assign adc_clk_en_out = s_r.adc_en;
	assign cpu_run_out = s_r.run;
	assign rc_osc_en_out = s_r.rc_osc_en;
	assign lf_osc_en_out = s_r.lf_osc_en;
	assign wdt_osc_en_out = s_r.wdt_osc_en;
	assign oscillator_trim_register_out = s_r.trim;
	assign s_axi_awready_out = s_r.awready;
	assign s_axi_wready_out = s_r.wready;
	assign s_axi_bresp_out = s_r.bresp;
	assign s_axi_bvalid_out = s_r.bvalid;
	assign s_axi_arready_out = s_r.arready;
	assign s_axi_rdata_out = s_r.rdata;
	assign s_axi_rresp_out = s_r.rresp;
	assign s_axi_rvalid_out = s_r.rvalid;

endmodule // ccs_clock_control

// file: src/ccs_pkg.sv
package ccs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Fuse codes, taken as stored (1 = unprogrammed, 0 = programmed)
	localparam logic [1:0] CCS_SRC_EXT  = 2'h0;
	localparam logic [1:0] CCS_SRC_RC48 = 2'h1;
	localparam logic [1:0] CCS_SRC_RC96 = 2'h2;
	localparam logic [1:0] CCS_SRC_LF   = 2'h3;
	localparam logic [1:0] CCS_SUT_SHORT = 2'h0;
	localparam logic [1:0] CCS_SUT_MID   = 2'h1;
	localparam logic [1:0] CCS_SUT_LONG  = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Start-up counts (source clock cycles or watchdog oscillator cycles)
	localparam int         CCS_CNT_W    = 14;
	localparam logic [13:0] CCS_WAKE_CK  = 14'h0006;
	localparam logic [13:0] CCS_RST_CK   = 14'h000e;
	localparam logic [13:0] CCS_WDT_4MS  = 14'h0200;
	localparam logic [13:0] CCS_WDT_64MS = 14'h2000;
	localparam logic [2:0]  CCS_DIV8_LAST = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses) and field positions
	localparam logic [7:0] CCS_TRIM_OFS   = 8'h00;
	localparam logic [7:0] CCS_STATUS_OFS = 8'h04;
	localparam int CCS_TRIM_W       = 7;
	localparam int CCS_ST_STATE_LSB = 0;
	localparam int CCS_ST_SRC_LSB   = 8;
	localparam int CCS_ST_SUT_LSB   = 10;
	localparam int CCS_ST_DIV8_BIT  = 12;
	localparam int CCS_ST_RUN_BIT   = 13;
	localparam logic [1:0] CCS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CCS_RESP_SLVERR = 2'h2;
	localparam logic [1:0] CCS_DEC_NONE   = 2'h0;
	localparam logic [1:0] CCS_DEC_TRIM   = 2'h1;
	localparam logic [1:0] CCS_DEC_STATUS = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic CCS_READY_RST   = 1'b1;
	localparam logic CCS_WDT_EN_RST  = 1'b1;

	typedef enum logic [5:0] {
		CCS_ST_RESET   = 6'h01,
		CCS_ST_RST_WDT = 6'h02,
		CCS_ST_RST_CK  = 6'h04,
		CCS_ST_RUN     = 6'h08,
		CCS_ST_SLEEP   = 6'h10,
		CCS_ST_WAKE    = 6'h20
	} ccs_state_type;

endpackage

// file: src/ccs_tick_counter.sv
module ccs_tick_counter (
	// Clock and reset
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_n_in,
	// Load and count
	input  wire logic                      load_in,
	input  wire logic [ccs_pkg::CCS_CNT_W-1:0] count_in,
	input  wire logic                      tick_in,
	// Status
	output logic                           busy_out,
	output logic                           done_out
);

	typedef struct packed {
		logic [ccs_pkg::CCS_CNT_W-1:0] cnt;
		logic                         done;
	} ccs_ctr_type;

	ccs_ctr_type s_r;
	ccs_ctr_type s_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (load_in) begin
			s_nxt.cnt = count_in;
		end else if (tick_in && (s_r.cnt != '0)) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
			s_nxt.done = (s_r.cnt == {{(ccs_pkg::CCS_CNT_W-1){1'b0}}, 1'b1});
		end
		if (!rst_n_in) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		s_r <= s_nxt;
	end

	assign busy_out = (s_r.cnt != '0);
	assign done_out = s_r.done;

endmodule // ccs_tick_counter

// file: test/ccs_ext_clk.sv
module ccs_ext_clk #(
	parameter int HALF = 4
) (
	// Clock and control
	input  wire logic clk_in,
	input  wire logic run_in,
	// Pin drive
	output logic      ext_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int n = 0;
	initial ext_out = 1'b0;
	// Fixed period: no cycle-to-cycle change at all
	// Rate changes belong to the prescaler, never to this source
	// Parked low while not selected, never left floating
	always @(posedge clk_in) begin
		n <= (n == 2 * HALF - 1) ? 0 : n + 1;
		ext_out <= run_in && (n < HALF);
	end
endmodule // ccs_ext_clk

// file: test/ccs_clock_control_sva.sv
module ccs_clock_control_sva (
	// Clock, reset, fuses
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire logic       divide_by_eight_fuse_in,
	input wire logic [6:0] cal_byte_fast_in,
	// Halts
	input wire logic       core_halt_in,
	input wire logic       io_halt_in,
	input wire logic       adc_halt_in,
	// Enables and status
	input wire logic       core_clk_en_out,
	input wire logic       io_clk_en_out,
	input wire logic       flash_clk_en_out,
	input wire logic       adc_clk_en_out,
	input wire logic       cpu_run_out,
	input wire logic       rc_osc_en_out,
	input wire logic       lf_osc_en_out,
	input wire logic       wdt_osc_en_out,
	input wire logic [6:0] oscillator_trim_register_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////
	// Halts are checked two cycles in, past the enable pipeline
	AST_CORE_HALT: assert property (
		core_halt_in && $past(core_halt_in, 2) |-> !core_clk_en_out)
		else $error("core enable while halted");
	AST_IO_HALT: assert property (
		io_halt_in && $past(io_halt_in, 2) |-> !io_clk_en_out)
		else $error("io enable while halted");
	AST_FLASH: assert property (
		flash_clk_en_out == core_clk_en_out)
		else $error("flash enable differs from core");
	AST_ADC_HALT: assert property (
		adc_halt_in && $past(adc_halt_in, 2) |-> !adc_clk_en_out)
		else $error("adc enable while halted");
	AST_OSC_SEL: assert property (
		!(rc_osc_en_out && lf_osc_en_out))
		else $error("two oscillators enabled");
	AST_WAKE: assert property (
		$fell(cpu_run_out) |=> !cpu_run_out [*6])
		else $error("run resumed too soon");
	AST_RST_DELAY: assert property (
		$rose(rst_n_in) |-> !cpu_run_out [*8])
		else $error("run too soon after reset");
	AST_TRIM: assert property (
		disable iff (1'b0)
		!rst_n_in |=> oscillator_trim_register_out == $past(cal_byte_fast_in))
		else $error("trim not loaded in reset");
	AST_WDT: assert property (
		wdt_osc_en_out)
		else $error("watchdog oscillator off");
	AST_DIV8: assert property (
		!divide_by_eight_fuse_in && core_clk_en_out |=> !core_clk_en_out [*7])
		else $error("divided enable too frequent");
	COV_RUN: cover property ($rose(cpu_run_out));
	COV_ADC: cover property (core_halt_in && io_halt_in && adc_clk_en_out);
	COV_DIV: cover property (!divide_by_eight_fuse_in && core_clk_en_out);
endmodule // ccs_clock_control_sva

bind ccs_clock_control ccs_clock_control_sva ccs_clock_control_sva_inst (.*);

// file: test/ccs_clock_control_tb_top.sv
module ccs_clock_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, ext_run = 1'b0;
	logic [1:0]  clock_source_select_in = 2'h0, startup_time_select_in = 2'h0;
	logic [6:0]  cal_byte_fast_in = 7'h00, cal_byte_slow_in = 7'h3c;
	logic        divide_by_eight_fuse_in = 1'b1, external_clock_input_in;
	logic        rc_osc_tick_in = 1'b1, wdt_osc_tick_in = 1'b1;
	logic        lf_osc_tick_in = 1'b0, power_down_in = 1'b0, wake_in = 1'b0;
	logic        ext_irq_async_in = 1'b0, core_halt_in = 1'b0;
	logic        io_halt_in = 1'b0, adc_halt_in = 1'b0;
	logic        core_clk_en_out, io_clk_en_out, flash_clk_en_out;
	logic        adc_clk_en_out, cpu_run_out, rc_osc_en_out;
	logic        lf_osc_en_out, wdt_osc_en_out;
	logic [6:0]  oscillator_trim_register_out;
	logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in = 4'h0;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, lf_div = 2'h0;
	logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic        s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
	logic        s_axi_rready_in = 1'b0, s_axi_awready_out;
	logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic        s_axi_rvalid_out;
	int          fails = 0, n_compared = 0, cyc = 0, t0 = 0;

	ccs_clock_control ccs_clock_control_inst (.*);
	ccs_ext_clk #(.HALF(4)) ccs_ext_clk_inst (
		.clk_in (sys_clk_in),
		.run_in (ext_run),
		.ext_out(external_clock_input_in)
	);

	always #12.5 sys_clk_in = ~sys_clk_in;
	// Slow source ticks every third cycle so each source has its own gap
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		lf_div <= (lf_div == 2'h2) ? 2'h0 : lf_div + 2'h1;
		lf_osc_tick_in <= (lf_div == 2'h2);
	end

	////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic rst(input logic [1:0] src, startup_time_select, input logic dv);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		clock_source_select_in <= src;
		startup_time_select_in <= startup_time_select;
		divide_by_eight_fuse_in <= dv;
		cal_byte_fast_in <= {src, startup_time_select, 3'h5};
		ext_run <= (src == ccs_pkg::CCS_SRC_EXT);
		repeat (9) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		chk(oscillator_trim_register_out, {src, startup_time_select, 3'h5});
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(negedge sys_clk_in);
		t0 = cyc;
	endtask

	task automatic wait_run(output int t);
		while (cpu_run_out !== 1'b1) @(negedge sys_clk_in);
		t = cyc - t0;
	endtask

	task automatic gap(output int g);
		int c0;
		while (core_clk_en_out !== 1'b1) @(negedge sys_clk_in);
		c0 = cyc;
		@(negedge sys_clk_in);
		while (core_clk_en_out !== 1'b1) @(negedge sys_clk_in);
		g = cyc - c0;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] b);
		logic ta = 1'b0, tw = 1'b0;
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(negedge sys_clk_in);
			ta |= s_axi_awready_out;
			tw |= s_axi_wready_out;
			@(posedge sys_clk_in);
			if (ta) s_axi_awvalid_in <= 1'b0;
			if (tw) s_axi_wvalid_in <= 1'b0;
		end while (!(ta && tw));
		do @(negedge sys_clk_in); while (s_axi_bvalid_out !== 1'b1);
		b = s_axi_bresp_out;
		@(posedge sys_clk_in);
		s_axi_bready_in <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do @(negedge sys_clk_in); while (s_axi_arready_out !== 1'b1);
		@(posedge sys_clk_in);
		s_axi_arvalid_in <= 1'b0;
		do @(negedge sys_clk_in); while (s_axi_rvalid_out !== 1'b1);
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		@(posedge sys_clk_in);
		s_axi_rready_in <= 1'b0;
	endtask

	////////////////////////////////
	task automatic test_sources();
		int t, g, p;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? 8 : (i == 1) ? 2 : (i == 2) ? 1 : 3;
			rst(2'(i), ccs_pkg::CCS_SUT_SHORT, 1'b1);
			wait_run(t);
			chk(t > 13 * p && t <= 15 * p + 4, 1);
			chk(rc_osc_en_out, i == 1 || i == 2);
			chk(lf_osc_en_out, i == 3);
			gap(g);
			chk(g, p);
			axr(ccs_pkg::CCS_STATUS_OFS, d, r);
			chk(d[13:8], {4'h8, 2'(i)});
		end
	endtask

	// Runs on the slow source left selected by the previous scenario
	task automatic test_sleep();
		int t;
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk_in);
			power_down_in <= 1'b1;
			@(posedge sys_clk_in);
			power_down_in <= 1'b0;
			repeat (4) @(negedge sys_clk_in);
			chk({cpu_run_out, lf_osc_en_out}, 2'h0);
			@(posedge sys_clk_in);
			wake_in <= (i == 0);
			ext_irq_async_in <= (i == 1);
			@(negedge sys_clk_in);
			t0 = cyc;
			wait_run(t);
			chk(t > 15 && t <= 23, 1);
			@(posedge sys_clk_in);
			wake_in <= 1'b0;
			ext_irq_async_in <= 1'b0;
		end
	endtask

	task automatic test_sut();
		int t, g;
		logic [31:0] d;
		logic [1:0] r;
		rst(ccs_pkg::CCS_SRC_RC96, ccs_pkg::CCS_SUT_MID, 1'b1);
		wait_run(t);
		chk(t > 526 && t <= 532, 1);
		rst(ccs_pkg::CCS_SRC_RC96, ccs_pkg::CCS_SUT_LONG, 1'b0);
		wait_run(t);
		chk(t > 8206 && t <= 8212, 1);
		gap(g);
		chk(g, 8);
		axr(ccs_pkg::CCS_STATUS_OFS, d, r);
		chk(d[12:8], 5'h1a);
	endtask

	task automatic test_halt();
		int c, f, io, a;
		// Reserved start-up code must behave as the longest delay
		rst(ccs_pkg::CCS_SRC_RC96, 2'h3, 1'b1);
		wait_run(c);
		chk(c > 8206 && c <= 8212, 1);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk_in);
			core_halt_in <= 1'b1;
			io_halt_in <= (i != 0);
			adc_halt_in <= (i == 2);
			repeat (3) @(posedge sys_clk_in);
			{c, f, io, a} = '0;
			repeat (24) begin
				@(negedge sys_clk_in);
				c += core_clk_en_out;
				f += flash_clk_en_out;
				io += io_clk_en_out;
				a += adc_clk_en_out;
			end
			chk(c + f, 0);
			chk(io, (i == 0) ? 24 : 0);
			chk(a, (i == 2) ? 0 : 24);
		end
		@(posedge sys_clk_in);
		core_halt_in <= 1'b0;
		io_halt_in <= 1'b0;
		adc_halt_in <= 1'b0;
	endtask

	task automatic test_trim();
		logic [31:0] d;
		logic [1:0] r, b;
		axw(ccs_pkg::CCS_TRIM_OFS, 32'h55, 4'hf, b);
		chk(b, ccs_pkg::CCS_RESP_OKAY);
		axr(ccs_pkg::CCS_TRIM_OFS, d, r);
		chk(d, 32'h55);
		axw(ccs_pkg::CCS_TRIM_OFS, 32'h11, 4'h0, b);
		axw(ccs_pkg::CCS_STATUS_OFS, 32'hffffffff, 4'hf, b);
		chk(b, ccs_pkg::CCS_RESP_OKAY);
		axw(8'h08, 32'h22, 4'hf, b);
		chk(b, ccs_pkg::CCS_RESP_SLVERR);
		axr(8'h08, d, r);
		chk(r, ccs_pkg::CCS_RESP_SLVERR);
		chk(d, 32'h0);
		chk(oscillator_trim_register_out, 7'h55);
	endtask

	initial begin
		test_sources();
		test_sleep();
		test_sut();
		test_halt();
		test_trim();
		test_done();
	end

	initial begin
		#(40000 * 25);
		fails++;
		test_done();
	end
endmodule // ccs_clock_control_tb_top
